// [hdl/cdop_consts.vh]
// constants of the cache debug observe port
`ifndef CDOP_CONSTS_VH
`define CDOP_CONSTS_VH

// ----------------------------------------------------------------------
// register select codes
// ----------------------------------------------------------------------
`define CDOP_SEL_STATUS   5'h00
`define CDOP_SEL_PBC      5'h01
`define CDOP_SEL_DBC      5'h02
`define CDOP_SEL_TRACE    5'h03
`define CDOP_SEL_DUL      5'h04
`define CDOP_SEL_DLL      5'h05
`define CDOP_SEL_PUL      5'h06
`define CDOP_SEL_PLL      5'h07
`define CDOP_SEL_XFER     5'h08
`define CDOP_SEL_PDL      5'h09
`define CDOP_SEL_FETCH    5'h0a
`define CDOP_SEL_ILAT     5'h0b
`define CDOP_SEL_CLR_PBC  5'h0c
`define CDOP_SEL_CLR_DBC  5'h0d
`define CDOP_SEL_CLR_TRC  5'h0e
`define CDOP_SEL_PAFIFO   5'h11
`define CDOP_SEL_TAGS     5'h12
`define CDOP_SEL_DECODE   5'h13
`define CDOP_SEL_NONE     5'h1f

// ----------------------------------------------------------------------
// command word fields, shifted in msb first
// ----------------------------------------------------------------------
`define CDOP_CMD_BITS     8
`define CDOP_CMD_READ     7
`define CDOP_CMD_GO       6
`define CDOP_CMD_EX       5
`define CDOP_CMD_SEL_HI   4
`define CDOP_CMD_SEL_LO   0

// ----------------------------------------------------------------------
// data and status layout
// ----------------------------------------------------------------------
`define CDOP_DATA_BITS    32
`define CDOP_CNT_LAST     6'h1f
`define CDOP_CMD_LAST     6'h07
`define CDOP_HIT_BIT      20
`define CDOP_TAG_WORDS    9
`define CDOP_PTR_LAST     4'h8
`define CDOP_PTR_RESET    4'h0
`define CDOP_STATUS_ENTRY 4'h8
`define CDOP_LRU_DEFAULT  8'h01

`endif

// [hdl/cdop_sync.v]
// two-flop synchroniser for the serial link inputs
`timescale 1ns/10ps
`default_nettype none

module cdop_sync (
  input  wire       clk_i,
  input  wire       rst_n_i,
  input  wire [1:0] async_i,
  output wire [1:0] sync_o
);

  reg [1:0] meta_r;
  reg [1:0] sync_r;

  // ----------------------------------------------------------------------
  // per-bit two flop chain
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_bit
      always @(posedge clk_i) begin
        if (!rst_n_i) begin
          meta_r[g] <= 1'b0;
          sync_r[g] <= 1'b0;
        end else begin
          meta_r[g] <= async_i[g];
          sync_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate

  assign sync_o = sync_r;

endmodule // cdop_sync

`default_nettype wire

// [hdl/cdop_tag_mem.v]
// nine-word tags buffer store with registered read data
`timescale 1ns/10ps
`default_nettype none
`include "cdop_consts.vh"

module cdop_tag_mem (
  input  wire        clk_i,
  input  wire        wr_en_i,
  input  wire [3:0]  wr_addr_i,
  input  wire [31:0] wr_data_i,
  input  wire [3:0]  rd_addr_i,
  output wire [31:0] rd_data_o
);

  reg [31:0] mem_r [0:`CDOP_TAG_WORDS-1];
  reg [31:0] rd_data_r;

  always @(posedge clk_i) begin
    if (wr_en_i && (wr_addr_i <= `CDOP_PTR_LAST)) begin
      mem_r[wr_addr_i] <= wr_data_i;
    end
    if (rd_addr_i <= `CDOP_PTR_LAST) begin
      rd_data_r <= mem_r[rd_addr_i];
    end else begin
      rd_data_r <= 32'h0000_0000;
    end
  end

  assign rd_data_o = rd_data_r;

endmodule // cdop_tag_mem

`default_nettype wire

// [hdl/cdop_top.v]
// cache debug observe port: command decode, hit flag and tags buffer
`timescale 1ns/10ps
`default_nettype none
`include "cdop_consts.vh"

module cdop_top (
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire        dsck_i,
  input  wire        dsi_i,
  output wire        dso_o,
  output wire        ack_o,
  input  wire        debug_mode_i,
  input  wire        cache_mode_i,
  input  wire        lookup_valid_i,
  input  wire        lookup_hit_i,
  input  wire        tag_wr_i,
  input  wire [2:0]  tag_idx_i,
  input  wire [31:0] tag_data_i,
  input  wire [7:0]  lock_bits_i,
  input  wire [7:0]  lru_bits_i,
  input  wire [31:0] ext_status_i,
  input  wire [31:0] ext_rdata_i,
  input  wire        instr_done_i,
  output wire [4:0]  ext_sel_o,
  output wire        ext_wr_o,
  output wire [31:0] ext_wdata_o,
  output wire        clr_pbc_o,
  output wire        clr_dbc_o,
  output wire        clr_trace_o,
  output wire [31:0] pdb_data_o,
  output wire        pdb_drive_o,
  output wire        core_load_o,
  output wire        release_o,
  output wire        exit_debug_o,
  output wire [7:0]  victim_o
);

  // ----------------------------------------------------------------------
  // states
  // ----------------------------------------------------------------------
  localparam [2:0] ST_CMD   = 3'd0;
  localparam [2:0] ST_DEC   = 3'd1;
  localparam [2:0] ST_FETCH = 3'd2;
  localparam [2:0] ST_RDOUT = 3'd3;
  localparam [2:0] ST_WRIN  = 3'd4;
  localparam [2:0] ST_RUN   = 3'd5;

  reg  [2:0]  state_r;
  reg  [7:0]  cmd_r;
  reg  [5:0]  cnt_r;
  reg  [31:0] shift_r;
  reg  [3:0]  ptr_r;
  reg         hit_r;
  reg         dbg_q_r;
  reg         sck_q_r;
  reg         ack_r;
  reg         dso_r;
  reg  [4:0]  ext_sel_r;
  reg         ext_wr_r;
  reg  [31:0] ext_wdata_r;
  reg         clr_pbc_r;
  reg         clr_dbc_r;
  reg         clr_trace_r;
  reg  [31:0] pdb_data_r;
  reg         pdb_drive_r;
  reg         core_load_r;
  reg         release_r;
  reg         exit_r;
  reg  [7:0]  victim_r;

  wire [1:0]  sync_w;
  wire        sck_w;
  wire        sdi_w;
  wire        rise_w;
  wire [31:0] mem_rdata_w;
  wire [4:0]  sel_w;
  wire        is_read_w;
  wire        go_w;
  wire        ex_w;
  wire        tags_w;
  wire        nodata_w;
  wire        reserved_w;
  wire [7:0]  lru_fix_w;
  wire [31:0] lru_word_w;
  wire        mem_wr_w;
  wire [3:0]  mem_waddr_w;
  wire [31:0] mem_wdata_w;
  wire [31:0] status_w;

  // ----------------------------------------------------------------------
  // link sampling
  // ----------------------------------------------------------------------
  cdop_sync u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .async_i ({dsck_i, dsi_i}),
    .sync_o  (sync_w)
  );

  assign sck_w  = sync_w[1];
  assign sdi_w  = sync_w[0];
  assign rise_w = sck_w & ~sck_q_r;

  // ----------------------------------------------------------------------
  // command fields and select classes
  // ----------------------------------------------------------------------
  assign sel_w     = cmd_r[`CDOP_CMD_SEL_HI:`CDOP_CMD_SEL_LO];
  assign is_read_w = cmd_r[`CDOP_CMD_READ];
  assign go_w      = cmd_r[`CDOP_CMD_GO];
  assign ex_w      = cmd_r[`CDOP_CMD_EX];
  assign tags_w    = (sel_w == `CDOP_SEL_TAGS);
  assign reserved_w = (sel_w == 5'h0f) || (sel_w == 5'h10) ||
                      (sel_w[4:2] == 3'b101) ||
                      ((sel_w[4:3] == 2'b11) && (sel_w != `CDOP_SEL_NONE));
  assign nodata_w  = (sel_w == `CDOP_SEL_CLR_PBC) ||
                     (sel_w == `CDOP_SEL_CLR_DBC) ||
                     (sel_w == `CDOP_SEL_CLR_TRC) ||
                     (sel_w == `CDOP_SEL_NONE) || reserved_w;

  // ----------------------------------------------------------------------
  // lock/lru word and victim
  // ----------------------------------------------------------------------
  assign lru_fix_w  = (lru_bits_i == 8'h00) ? `CDOP_LRU_DEFAULT
                                            : lru_bits_i;
  assign lru_word_w = {16'h0000, lock_bits_i, lru_fix_w};

  // tags from the cache controller, otherwise refresh the ninth word
  assign mem_wr_w    = 1'b1;
  assign mem_waddr_w = tag_wr_i ? {1'b0, tag_idx_i} : `CDOP_STATUS_ENTRY;
  assign mem_wdata_w = tag_wr_i ? tag_data_i : lru_word_w;

  cdop_tag_mem u_mem (
    .clk_i     (clk_i),
    .wr_en_i   (mem_wr_w),
    .wr_addr_i (mem_waddr_w),
    .wr_data_i (mem_wdata_w),
    .rd_addr_i (ptr_r),
    .rd_data_o (mem_rdata_w)
  );

  // hit flag masked outside cache mode
  assign status_w = {ext_status_i[31:`CDOP_HIT_BIT+1],
                     hit_r & cache_mode_i,
                     ext_status_i[`CDOP_HIT_BIT-1:0]};

  // ----------------------------------------------------------------------
  // hit flag, edge-detect delays and victim
  // ----------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      hit_r    <= 1'b0;
      dbg_q_r  <= 1'b0;
      sck_q_r  <= 1'b0;
      victim_r <= 8'h00;
    end else begin
      dbg_q_r  <= debug_mode_i;
      sck_q_r  <= sck_w;
      victim_r <= lru_fix_w & ~lock_bits_i;
      if (lookup_valid_i && cache_mode_i && debug_mode_i) begin
        hit_r <= lookup_hit_i;
      end
    end
  end

  // ----------------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_r     <= ST_CMD;
      cmd_r       <= 8'h00;
      cnt_r       <= 6'h00;
      shift_r     <= 32'h0000_0000;
      ptr_r       <= `CDOP_PTR_RESET;
      ack_r       <= 1'b0;
      dso_r       <= 1'b0;
      ext_sel_r   <= `CDOP_SEL_NONE;
      ext_wr_r    <= 1'b0;
      ext_wdata_r <= 32'h0000_0000;
      clr_pbc_r   <= 1'b0;
      clr_dbc_r   <= 1'b0;
      clr_trace_r <= 1'b0;
      pdb_data_r  <= 32'h0000_0000;
      pdb_drive_r <= 1'b0;
      core_load_r <= 1'b0;
      release_r   <= 1'b0;
      exit_r      <= 1'b0;
    end else begin
      ext_wr_r    <= 1'b0;
      clr_pbc_r   <= 1'b0;
      clr_dbc_r   <= 1'b0;
      clr_trace_r <= 1'b0;
      core_load_r <= 1'b0;
      release_r   <= 1'b0;
      exit_r      <= 1'b0;
      if (rise_w) begin
        ack_r <= 1'b0;
      end
      if (dbg_q_r && !debug_mode_i) begin
        ptr_r <= `CDOP_PTR_RESET;
      end
      case (state_r)
        ST_CMD: begin
          if (rise_w) begin
            cmd_r <= {cmd_r[6:0], sdi_w};
            if (cnt_r == `CDOP_CMD_LAST) begin
              cnt_r   <= 6'h00;
              state_r <= ST_DEC;
            end else begin
              cnt_r <= cnt_r + 6'h01;
            end
          end
        end
        ST_DEC: begin
          ext_sel_r <= sel_w;
          if (tags_w && !(dbg_q_r && !debug_mode_i)) begin
            if (ptr_r == `CDOP_PTR_LAST) begin
              ptr_r <= `CDOP_PTR_RESET;
            end else begin
              ptr_r <= ptr_r + 4'h1;
            end
          end
          if (nodata_w) begin
            if (sel_w == `CDOP_SEL_CLR_PBC) begin
              clr_pbc_r <= 1'b1;
            end else if (sel_w == `CDOP_SEL_CLR_DBC) begin
              clr_dbc_r <= 1'b1;
            end else if (sel_w == `CDOP_SEL_CLR_TRC) begin
              clr_trace_r <= 1'b1;
            end
            if (go_w) begin
              release_r <= 1'b1;
              exit_r    <= ex_w;
              state_r   <= ST_RUN;
            end else begin
              ack_r   <= 1'b1;
              state_r <= ST_CMD;
            end
          end else if (is_read_w) begin
            state_r <= ST_FETCH;
          end else begin
            ack_r   <= 1'b1;
            state_r <= ST_WRIN;
          end
        end
        ST_FETCH: begin
          // read never drives anything toward the cache
          if (sel_w == `CDOP_SEL_STATUS) begin
            shift_r <= status_w;
          end else if (tags_w) begin
            shift_r <= mem_rdata_w;
          end else begin
            shift_r <= ext_rdata_i;
          end
          ack_r   <= 1'b1;
          state_r <= ST_RDOUT;
        end
        ST_RDOUT: begin
          dso_r <= shift_r[31];
          if (rise_w) begin
            shift_r <= {shift_r[30:0], 1'b0};
            if (cnt_r == `CDOP_CNT_LAST) begin
              cnt_r <= 6'h00;
              if (go_w) begin
                release_r <= 1'b1;
                exit_r    <= ex_w;
                state_r   <= ST_RUN;
              end else begin
                state_r <= ST_CMD;
              end
            end else begin
              cnt_r <= cnt_r + 6'h01;
            end
          end
        end
        ST_WRIN: begin
          if (rise_w) begin
            shift_r <= {shift_r[30:0], sdi_w};
            if (cnt_r == `CDOP_CNT_LAST) begin
              cnt_r <= 6'h00;
              if (sel_w == `CDOP_SEL_PDL) begin
                pdb_data_r  <= {shift_r[30:0], sdi_w};
                pdb_drive_r <= 1'b1;
              end else if (!tags_w) begin
                ext_wr_r    <= 1'b1;
                ext_wdata_r <= {shift_r[30:0], sdi_w};
              end
              if (go_w) begin
                release_r <= 1'b1;
                exit_r    <= ex_w;
                state_r   <= ST_RUN;
              end else begin
                core_load_r <= (sel_w == `CDOP_SEL_PDL);
                ack_r       <= 1'b1;
                state_r     <= ST_CMD;
              end
            end else begin
              cnt_r <= cnt_r + 6'h01;
            end
          end
        end
        ST_RUN: begin
          if (instr_done_i) begin
            pdb_drive_r <= 1'b0;
            ack_r       <= 1'b1;
            state_r     <= ST_CMD;
          end
        end
        default: begin
          state_r <= ST_CMD;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign dso_o        = dso_r;
  assign ack_o        = ack_r;
  assign ext_sel_o    = ext_sel_r;
  assign ext_wr_o     = ext_wr_r;
  assign ext_wdata_o  = ext_wdata_r;
  assign clr_pbc_o    = clr_pbc_r;
  assign clr_dbc_o    = clr_dbc_r;
  assign clr_trace_o  = clr_trace_r;
  assign pdb_data_o   = pdb_data_r;
  assign pdb_drive_o  = pdb_drive_r;
  assign core_load_o  = core_load_r;
  assign release_o    = release_r;
  assign exit_debug_o = exit_r;
  assign victim_o     = victim_r;

endmodule // cdop_top

`default_nettype wire

// [bench/cdop_chk_sva.sv]
// assertions on the ports of the cache debug observe port
`timescale 1ns/10ps
`default_nettype none
`include "cdop_consts.vh"

module cdop_chk (
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic       dsck_i,
  input wire logic       ack_o,
  input wire logic       instr_done_i,
  input wire logic [7:0] lock_bits_i,
  input wire logic [7:0] lru_bits_i,
  input wire logic [7:0] victim_o,
  input wire logic [4:0] ext_sel_o,
  input wire logic       ext_wr_o,
  input wire logic       clr_pbc_o,
  input wire logic       clr_dbc_o,
  input wire logic       clr_trace_o,
  input wire logic       pdb_drive_o,
  input wire logic       core_load_o,
  input wire logic       release_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire [7:0] vic_exp = ((lru_bits_i == 8'h00) ? `CDOP_LRU_DEFAULT :
                        lru_bits_i) & ~lock_bits_i;

  a_victim_calc: assert property (
    rst_n_i && $stable(lock_bits_i) && $stable(lru_bits_i) |=>
    victim_o == $past(vic_exp)) else $error("victim wrong");
  a_clr_sel: assert property (
    clr_pbc_o |-> ext_sel_o == `CDOP_SEL_CLR_PBC)
    else $error("clear without its select");
  a_clr_onehot: assert property (
    $onehot0({clr_pbc_o, clr_dbc_o, clr_trace_o, ext_wr_o}))
    else $error("pulses overlap");
  a_wr_legal: assert property (
    ext_wr_o |-> ext_sel_o < 5'h0c || ext_sel_o == 5'h11 ||
    ext_sel_o == 5'h13) else $error("write to bad select");
  a_drive_start: assert property (
    $rose(pdb_drive_o) |-> release_o || core_load_o)
    else $error("bus driven without load");
  a_drive_done: assert property (
    pdb_drive_o && instr_done_i |=> !pdb_drive_o && ack_o)
    else $error("no ack after done");
  a_ack_hold: assert property (
    $rose(ack_o) |=> ack_o [*2]) else $error("ack too short");
  a_ack_clear: assert property (
    $fell(ack_o) |-> dsck_i) else $error("ack dropped early");

  c_tags_read: cover property (ack_o && ext_sel_o == `CDOP_SEL_TAGS);
  c_release: cover property (release_o && pdb_drive_o);
  c_no_victim: cover property (lock_bits_i == 8'hff && victim_o == 8'h00);
endmodule // cdop_chk

bind cdop_top cdop_chk cdop_chk_inst (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .dsck_i(dsck_i), .ack_o(ack_o),
  .instr_done_i(instr_done_i), .lock_bits_i(lock_bits_i),
  .lru_bits_i(lru_bits_i), .victim_o(victim_o), .ext_sel_o(ext_sel_o),
  .ext_wr_o(ext_wr_o), .clr_pbc_o(clr_pbc_o), .clr_dbc_o(clr_dbc_o),
  .clr_trace_o(clr_trace_o), .pdb_drive_o(pdb_drive_o),
  .core_load_o(core_load_o), .release_o(release_o));
`default_nettype wire

// [bench/cdop_ctrl.sv]
// model of the external serial debug command controller
`timescale 1ns/10ps
`default_nettype none

module cdop_ctrl (
  input  wire logic clk_i,
  input  wire logic dso_i,
  input  wire logic ack_i,
  output var  logic dsck_o,
  output var  logic dsi_o
);
  int gap = 0;
  initial begin
    dsck_o = 1'b0;
    dsi_o = 1'b1;
  end
  // link clock idles low; a released data line shows the inverse
  task automatic tick(input logic b);
    dsi_o = b;
    #62.5 dsck_o = 1'b1;
    #62.5 dsck_o = 1'b0;
  endtask
  task automatic wait_ack(output logic ok);
    int n;
    n = 0;
    while (ack_i !== 1'b1 && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    ok = ack_i;
    repeat (3 + gap) @(posedge clk_i);
  endtask
  // off-grid start keeps link edges away from core edges
  task automatic cmd(input logic [7:0] c, output logic ok);
    @(posedge clk_i);
    #1.25;
    for (int i = 7; i >= 0; i--) tick(c[i]);
    dsi_o = ~c[0];
    wait_ack(ok);
  endtask
  task automatic word(input logic [31:0] wo, output logic [31:0] wi);
    @(posedge clk_i);
    #1.25;
    for (int i = 31; i >= 0; i--) begin
      wi[i] = dso_i;
      tick(wo[i]);
    end
    dsi_o = ~wo[0];
  endtask
endmodule // cdop_ctrl
`default_nettype wire

// [bench/cdop_top_tb.sv]
// self-checking bench of the cache debug observe port
`timescale 1ns/10ps
`default_nettype none

module cdop_top_tb;
  localparam logic [31:0] ST = 32'h00f0_0f0f;
  localparam logic [31:0] SN = 32'h00e0_0f0f;
  logic clk_i = 1'b0, rst_n_i = 1'b0, debug_mode_i = 1'b1;
  logic cache_mode_i = 1'b1, lookup_valid_i = 1'b0, lookup_hit_i = 1'b0;
  logic tag_wr_i = 1'b0, instr_done_i = 1'b0;
  logic [2:0]  tag_idx_i = 3'h0;
  logic [31:0] tag_data_i = 32'h0, wlast = 32'h0;
  logic [7:0]  lock_bits_i = 8'h0c, lru_bits_i = 8'h24, victim_o;
  logic [31:0] ext_wdata_o, pdb_data_o;
  logic [4:0]  ext_sel_o;
  logic dsck_i, dsi_i, dso_o, ack_o, ext_wr_o, clr_pbc_o, clr_dbc_o;
  logic clr_trace_o, pdb_drive_o, core_load_o, release_o, exit_debug_o;
  logic [3:0]  dly = 4'h0;
  int cyc = 0, fail_count = 0, cmp_count = 0;
  int pc [7];
  wire [31:0] ext_rdata_i = {27'h1234567, ext_sel_o};
  wire [6:0] pv = {exit_debug_o, ext_wr_o, core_load_o, release_o,
                   clr_trace_o, clr_dbc_o, clr_pbc_o};

  cdop_top cdop_top_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .dsck_i(dsck_i), .dsi_i(dsi_i),
    .dso_o(dso_o), .ack_o(ack_o), .debug_mode_i(debug_mode_i),
    .cache_mode_i(cache_mode_i), .lookup_valid_i(lookup_valid_i),
    .lookup_hit_i(lookup_hit_i), .tag_wr_i(tag_wr_i),
    .tag_idx_i(tag_idx_i), .tag_data_i(tag_data_i),
    .lock_bits_i(lock_bits_i), .lru_bits_i(lru_bits_i),
    .ext_status_i(ST), .ext_rdata_i(ext_rdata_i),
    .instr_done_i(instr_done_i), .ext_sel_o(ext_sel_o),
    .ext_wr_o(ext_wr_o), .ext_wdata_o(ext_wdata_o),
    .clr_pbc_o(clr_pbc_o), .clr_dbc_o(clr_dbc_o),
    .clr_trace_o(clr_trace_o), .pdb_data_o(pdb_data_o),
    .pdb_drive_o(pdb_drive_o), .core_load_o(core_load_o),
    .release_o(release_o), .exit_debug_o(exit_debug_o),
    .victim_o(victim_o));
  cdop_ctrl cdop_ctrl_inst (.clk_i(clk_i), .dso_i(dso_o), .ack_i(ack_o),
    .dsck_o(dsck_i), .dsi_o(dsi_i));

  initial forever #4 clk_i = ~clk_i;

  // pulse counts, core model finishing injected words, hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    for (int k = 0; k < 7; k++)
      if (pv[k]) pc[k] <= pc[k] + 1;
    if (ext_wr_o) wlast <= ext_wdata_o;
    dly <= release_o ? 4'h5 : (dly != 4'h0 ? dly - 4'h1 : 4'h0);
    instr_done_i <= (dly == 4'h1);
    if (cyc == 60000) begin
      fail_count++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic op(input logic [7:0] c);
    logic ok;
    cdop_ctrl_inst.cmd(c, ok);
    chk("ack", {31'h0, ok}, 32'h1);
  endtask
  task automatic rd(input logic [4:0] s, output logic [31:0] d);
    op({3'b100, s});
    cdop_ctrl_inst.word(32'h0, d);
  endtask
  task automatic wr(input logic [7:0] c, input logic [31:0] w);
    logic [31:0] d;
    op(c);
    cdop_ctrl_inst.word(w, d);
  endtask
  task automatic look(input logic h);
    @(posedge clk_i);
    lookup_valid_i <= 1'b1;
    lookup_hit_i <= h;
    @(posedge clk_i);
    lookup_valid_i <= 1'b0;
  endtask
  task automatic setlk(input logic [7:0] lk, ru);
    @(posedge clk_i);
    lock_bits_i <= lk;
    lru_bits_i <= ru;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic t_hit;
    logic [31:0] d;
    rd(5'h00, d);
    chk("hit_rst", d, SN);
    look(1'b1);
    rd(5'h00, d);
    chk("hit_set", d, ST);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rd(5'h00, d);
    chk("hit_rst2", d, SN);
    look(1'b1);
    @(posedge clk_i);
    cache_mode_i <= 1'b0;
    rd(5'h00, d);
    chk("hit_program_ram_mode", d, SN);
    @(posedge clk_i);
    cache_mode_i <= 1'b1;
    look(1'b0);
    rd(5'h00, d);
    chk("hit_miss", d, SN);
  endtask
  task automatic t_tags;
    logic [31:0] d;
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_i);
      tag_wr_i <= 1'b1;
      tag_idx_i <= 3'(k);
      tag_data_i <= 32'hd0d0_0000 + 32'(k);
    end
    @(posedge clk_i);
    tag_wr_i <= 1'b0;
    rd(5'h09, d);
    rd(5'h0b, d);
    for (int k = 0; k < 10; k++) begin
      rd(5'h12, d);
      chk("tag", d, k == 8 ? 32'hc24 : 32'hd0d0_0000 + 32'(k % 9));
    end
    chk("victim", {24'h0, victim_o}, 32'h20);
    setlk(8'hff, 8'hff);
    chk("no_victim", {24'h0, victim_o}, 32'h0);
    setlk(8'h00, 8'h00);
    chk("lru_min", {24'h0, victim_o}, 32'h1);
    setlk(8'h0c, 8'h24);
  endtask
  task automatic t_ptr;
    logic [31:0] d;
    cdop_ctrl_inst.gap = 20;
    rd(5'h0a, d);
    rd(5'h12, d);
    chk("ptr_hold", d, 32'hd0d0_0001);
    @(posedge clk_i);
    debug_mode_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    debug_mode_i <= 1'b1;
    rd(5'h12, d);
    chk("ptr_clr", d, 32'hd0d0_0000);
    cdop_ctrl_inst.gap = 0;
  endtask
  task automatic t_dec;
    logic [31:0] d;
    logic [4:0] rs [12] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06,
                            5'h07, 5'h08, 5'h0a, 5'h0b, 5'h11, 5'h13};
    logic [4:0] nd [7] = '{5'h0f, 5'h10, 5'h14, 5'h18, 5'h1c, 5'h1e, 5'h1f};
    int p [7];
    foreach (rs[k]) begin
      rd(rs[k], d);
      chk("sel_data", d, {27'h1234567, rs[k]});
    end
    for (int k = 0; k < 3; k++) begin
      p = pc;
      op(8'h0c + 8'(k));
      chk("clear", pc[k] - p[k], 32'h1);
    end
    foreach (nd[k]) op({3'b100, nd[k]});
    rd(5'h01, d);
    chk("after_rsv", d, {27'h1234567, 5'h01});
    wr(8'h08, 32'h1234_5678);
    repeat (2) @(posedge clk_i);
    chk("xfer_wr", wlast, 32'h1234_5678);
  endtask
  task automatic t_probe;
    logic ok;
    logic [31:0] d, keep;
    rd(5'h08, keep);
    wr(8'h48, 32'h0000_0040);
    cdop_ctrl_inst.wait_ack(ok);
    chk("ptr_load", wlast, 32'h0000_0040);
    for (int k = 0; k < 2; k++) begin
      wr(8'h49, 32'h0a10_0020 + 32'(k));
      look(k == 0);
      cdop_ctrl_inst.wait_ack(ok);
      chk("probe_ack", {31'h0, ok}, 32'h1);
      rd(5'h00, d);
      chk("probe_hit", d, k == 0 ? ST : SN);
    end
    wr(8'h48, keep);
    cdop_ctrl_inst.wait_ack(ok);
    chk("ptr_restore", wlast, keep);
  endtask
  task automatic t_go;
    logic ok;
    int p [7];
    p = pc;
    wr(8'h49, 32'h0a10_0010);
    cdop_ctrl_inst.wait_ack(ok);
    chk("go_ack", {31'h0, ok}, 32'h1);
    chk("go_bus", pdb_data_o, 32'h0a10_0010);
    chk("go_run", pc[3] - p[3], 32'h1);
    wr(8'h09, 32'h0c3f_8000);
    repeat (4) @(posedge clk_i);
    chk("load", pc[4] - p[4], 32'h1);
    op(8'h7f);
    chk("exit", pc[6] - p[6], 32'h1);
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    t_hit();
    t_tags();
    t_ptr();
    t_dec();
    t_probe();
    t_go();
    results();
  end
endmodule // cdop_top_tb
`default_nettype wire
